// ===== design/tiors_sequencer.sv
//----------------------------------------------------------------------
// Purpose: Test I/O device response sequencer with APB registers
// Assumes: Go bit starts selection; this block raises address out and select out
// Notes:   Status word store and logout run outside this block
//----------------------------------------------------------------------
// Behaviour
// - Status in with address out sets busy and sequence latches, starts clock.
// - Busy unit latch suppresses service out reply to status in.
// - Busy case drops select out at phase four unless halt busy.
// - Busy case: status in falls, drop address out, request status store.
// - Operational in clears address out; gated address in formed.
// - Operational in with gated address in starts clock and compares.
// - Address mismatch at phase one sets interface check latch.
// - Logout switch chooses logout then store, else fault reset path.
// - Interface check with machine check fires 300 ns pulse, sets suppress, starts 6 us reset.
// - Suppress blocks the software machine reset.
// - Interface reset starts store and holds operational out low.
// - Address match clears setup and drives zero proceed byte, odd parity.
// - Phase seven with gated address in raises command out.
// - Address in drop removes gated address in and command out.
// - Status in sets sequence latch; phase two captures status byte.
// - Phase three with status in sets status end, answering service out.
// - Phase four drops select out; status in fall clears status end.
// - Zero status takes available path, else status store.
// - Available path gives code zero, accept, release, clears on drop.
`timescale 1ns/1ps
module tiors_sequencer
  import tiors_pkg::*;
#(
  parameter int PHASE_CYCLES = 4
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Channel interface pins
  input  wire logic        i_status_in,
  input  wire logic        i_oper_in,
  input  wire logic        i_addr_in,
  input  wire logic [7:0]  i_bus_in,
  output logic             o_address_out,
  output logic             o_select_out,
  output logic             o_command_out,
  output logic             o_service_out,
  output logic             o_oper_out,
  output logic      [7:0]  o_bus_out,
  output logic             o_bus_out_parity,
  // Processor side
  input  wire logic        i_test_io,
  input  wire logic        i_select_channel,
  output logic      [1:0]  o_condition_code,
  output logic             o_accept,
  output logic             o_release,
  output logic             o_machine_check,
  output logic             o_iface_reset,
  // Store and logout routines
  output logic             o_csw_store,
  input  wire logic        i_store_done,
  output logic             o_logout,
  input  wire logic        i_logout_done
);

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  localparam int SW = 11;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] pin;

  assign pin_raw = {i_bus_in, i_addr_in, i_oper_in, i_status_in};

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_agree
      always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
          pin[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          pin[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  logic       status_in;
  logic       oper_in;
  logic       addr_in;
  logic [7:0] bus_in;
  assign status_in = pin[0];
  assign oper_in   = pin[1];
  assign addr_in   = pin[2];
  assign bus_in    = pin[10:3];

  //--------------------------------------------------------------------
  // APB registers
  //--------------------------------------------------------------------
  logic       logout_on_fault_switch;
  logic       halt_busy;
  logic       start_io;
  logic       cc_latch;
  logic [7:0] unit_addr;
  logic       wr;
  logic       rd_setup;
  logic       go;
  logic       mreset_req;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CONTROL) || (a == OFS_UNIT) ||
             (a == OFS_STATE) || (a == OFS_RESULT);
  endfunction : mapped

  assign wr         = i_psel && i_penable && i_pwrite && mapped(i_paddr);
  assign rd_setup   = i_psel && !i_penable && !i_pwrite;
  assign go         = wr && i_paddr == OFS_CONTROL && i_pwdata[CTL_GO];
  assign mreset_req = wr && i_paddr == OFS_CONTROL &&
                      i_pwdata[CTL_MRESET];
  assign o_pready   = 1'b1;
  assign o_pslverr  = i_psel && i_penable && !mapped(i_paddr);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      logout_on_fault_switch <= 1'b0;
      halt_busy              <= 1'b0;
      start_io               <= 1'b0;
      cc_latch               <= 1'b0;
      unit_addr              <= 8'h00;
    end else if (wr && i_paddr == OFS_CONTROL) begin
      logout_on_fault_switch <= i_pwdata[CTL_LOGOUT_SW];
      halt_busy              <= i_pwdata[CTL_HALT_BUSY];
      start_io               <= i_pwdata[CTL_START_IO];
      cc_latch               <= i_pwdata[CTL_CC_LATCH];
    end else if (wr && i_paddr == OFS_UNIT) begin
      unit_addr <= i_pwdata[7:0];
    end
  end

  //--------------------------------------------------------------------
  // Timing pieces
  //--------------------------------------------------------------------
  tiors_state_e           state;
  logic                   clk_run;
  logic [PHASE_COUNT-1:0] phase;
  logic                   iface_check;
  logic                   iface_check_q;
  logic                   ss_active;
  logic                   ss_start;
  logic                   ss_done;
  logic                   ifr_done;
  logic                   suppress;
  logic                   soft_clr;

  tiors_phase_clock #(.PHASE_CYCLES(PHASE_CYCLES)) u_phase (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_run   (clk_run),
    .o_phase (phase)
  );

  assign ss_start = iface_check && !iface_check_q && o_machine_check;

  tiors_pulse_timer #(.LENGTH(ONESHOT_CYCLES)) u_oneshot (
    .i_clock  (i_clock),
    .i_rstn   (i_rstn),
    .i_fire   (ss_start),
    .o_active (ss_active),
    .o_done   (ss_done)
  );

  tiors_pulse_timer #(.LENGTH(IFRESET_CYCLES)) u_ifreset (
    .i_clock  (i_clock),
    .i_rstn   (i_rstn),
    .i_fire   (ss_start),
    .o_active (o_iface_reset),
    .o_done   (ifr_done)
  );

  assign soft_clr   = mreset_req && !suppress;
  assign o_oper_out = !o_iface_reset;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      suppress      <= 1'b0;
      iface_check_q <= 1'b0;
    end else begin
      iface_check_q <= iface_check;
      if (ss_active) begin
        suppress <= 1'b1;
      end else if (i_store_done) begin
        suppress <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  logic       gated_addr_in;
  logic       busy_unit;
  logic       seq_latch;
  logic       setup;
  logic       test_io;
  logic       status_end;
  logic [7:0] status_byte;
  logic       status_taken;
  logic       store_req;

  assign gated_addr_in = addr_in && !start_io && !cc_latch;
  assign o_service_out = status_end && !busy_unit;
  assign o_csw_store   = store_req;
  assign o_logout      = state == ST_LOGOUT;
  assign o_accept      = state == ST_AVAIL;

  always_ff @(posedge i_clock) begin
    if (!i_rstn || soft_clr) begin
      state            <= ST_IDLE;
      clk_run          <= 1'b0;
      o_address_out    <= 1'b0;
      o_select_out     <= 1'b0;
      o_command_out    <= 1'b0;
      o_bus_out        <= 8'h00;
      o_bus_out_parity <= 1'b0;
      busy_unit        <= 1'b0;
      seq_latch        <= 1'b0;
      setup            <= 1'b0;
      test_io          <= 1'b0;
      status_end       <= 1'b0;
      status_byte      <= 8'h00;
      status_taken     <= 1'b0;
      iface_check      <= 1'b0;
      o_machine_check  <= 1'b0;
      store_req        <= 1'b0;
      o_condition_code <= 2'b00;
      o_release        <= 1'b0;
    end else begin
      o_release <= 1'b0;
      if (o_iface_reset) begin
        store_req <= 1'b1;
      end else if (store_req && i_store_done) begin
        store_req       <= 1'b0;
        iface_check     <= 1'b0;
        o_machine_check <= 1'b0;
        busy_unit       <= 1'b0;
        seq_latch       <= 1'b0;
        setup           <= 1'b0;
        test_io         <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (go) begin
            o_address_out    <= 1'b1;
            o_select_out     <= 1'b1;
            setup            <= 1'b1;
            test_io          <= 1'b1;
            status_taken     <= 1'b0;
            o_bus_out        <= unit_addr;
            o_bus_out_parity <= ~^unit_addr;
            state            <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (status_in && o_address_out) begin
            busy_unit <= 1'b1;
            seq_latch <= 1'b1;
            clk_run   <= 1'b1;
            state     <= ST_BUSY;
          end else if (oper_in) begin
            o_address_out <= 1'b0;
            if (gated_addr_in) begin
              clk_run <= 1'b1;
              state   <= ST_COMPARE;
            end
          end
        end
        ST_BUSY: begin
          if (phase[4] && !halt_busy) begin
            o_select_out <= 1'b0;
          end
          if (!o_select_out && !status_in) begin
            o_address_out <= 1'b0;
            clk_run       <= 1'b0;
            store_req     <= 1'b1;
            state         <= ST_IDLE;
          end
        end
        ST_COMPARE: begin
          if (phase[1]) begin
            if (bus_in != unit_addr) begin
              iface_check <= 1'b1;
              clk_run     <= 1'b0;
              if (logout_on_fault_switch) begin
                state <= ST_LOGOUT;
              end else begin
                o_machine_check <= 1'b1;
                state           <= ST_IFCHECK;
              end
            end else begin
              setup            <= 1'b0;
              o_bus_out        <= PROCEED_CMD;
              o_bus_out_parity <= ~^PROCEED_CMD;
              state            <= ST_COMMAND;
            end
          end
        end
        ST_IFCHECK: begin
          if (ifr_done) begin
            state <= ST_IDLE;
          end
        end
        ST_LOGOUT: begin
          if (i_logout_done) begin
            store_req <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        ST_COMMAND: begin
          if (!gated_addr_in) begin
            o_command_out <= 1'b0;
          end else if (phase[7]) begin
            o_command_out <= 1'b1;
          end
          if (!o_command_out && !addr_in && status_in) begin
            seq_latch <= 1'b1;
            state     <= ST_STATUS;
          end
        end
        ST_STATUS: begin
          if (phase[2] && status_in) begin
            status_byte  <= bus_in;
            status_taken <= 1'b1;
          end
          if (phase[3] && status_in && status_taken) begin
            status_end <= 1'b1;
          end
          if (phase[4] && status_end) begin
            o_select_out <= 1'b0;
          end
          if (status_end && !status_in) begin
            status_end <= 1'b0;
            clk_run    <= 1'b0;
            if (status_byte == 8'h00) begin
              o_condition_code <= 2'b00;
              o_release        <= 1'b1;
              state            <= ST_AVAIL;
            end else begin
              store_req <= 1'b1;
              state     <= ST_IDLE;
            end
          end
        end
        ST_AVAIL: begin
          if (!i_test_io && !i_select_channel) begin
            setup     <= 1'b0;
            test_io   <= 1'b0;
            seq_latch <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_prdata <= ZERO_WORD;
    end else if (rd_setup) begin
      case (i_paddr)
        OFS_CONTROL: o_prdata <= {26'h0, 1'b0, cc_latch, start_io,
                                  halt_busy, logout_on_fault_switch,
                                  1'b0};
        OFS_UNIT:    o_prdata <= {24'h0, unit_addr};
        OFS_STATE:   o_prdata <= {16'h0, suppress, iface_check,
                                  status_end, test_io, setup, seq_latch,
                                  busy_unit, 9'(state)};
        OFS_RESULT:  o_prdata <= {22'h0, o_condition_code, status_byte};
        default:     o_prdata <= ZERO_WORD;
      endcase
    end
  end

endmodule : tiors_sequencer

// ===== design/tiors_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants for the test I/O response sequencer
// Assumes: 125 MHz clock, APB register access
// Notes:   Register offsets are byte addresses
//----------------------------------------------------------------------
package tiors_pkg;

  //--------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 8000;
  localparam int ONESHOT_NS      = 300;
  localparam int IFRESET_US      = 6;
  localparam int ONESHOT_CYCLES  =
    (ONESHOT_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int IFRESET_CYCLES  =
    (IFRESET_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int PHASE_COUNT     = 8;

  //--------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNIT    = 8'h04;
  localparam logic [7:0] OFS_STATE   = 8'h08;
  localparam logic [7:0] OFS_RESULT  = 8'h0C;

  // Control bits
  localparam int CTL_GO        = 0;
  localparam int CTL_LOGOUT_SW = 1;
  localparam int CTL_HALT_BUSY = 2;
  localparam int CTL_START_IO  = 3;
  localparam int CTL_CC_LATCH  = 4;
  localparam int CTL_MRESET    = 5;

  localparam logic [7:0]  PROCEED_CMD = 8'h00;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  //--------------------------------------------------------------------
  // Sequencer states
  //--------------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_WAIT    = 9'h002,
    ST_BUSY    = 9'h004,
    ST_COMPARE = 9'h008,
    ST_IFCHECK = 9'h010,
    ST_LOGOUT  = 9'h020,
    ST_COMMAND = 9'h040,
    ST_STATUS  = 9'h080,
    ST_AVAIL   = 9'h100
  } tiors_state_e;

endpackage : tiors_pkg

// ===== design/tiors_phase_clock.sv
//----------------------------------------------------------------------
// Purpose: Gated eight-phase sequencer clock
// Assumes: Phase length is a whole number of system cycles
// Notes:   Rests at phase zero while stopped
//----------------------------------------------------------------------
`timescale 1ns/1ps
module tiors_phase_clock
  import tiors_pkg::*;
#(
  parameter int PHASE_CYCLES = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  // Control
  input  wire logic             i_run,
  // Phase outputs, one-hot
  output logic [PHASE_COUNT-1:0] o_phase
);

  generate
    if (PHASE_CYCLES < 1 || PHASE_CYCLES > 65536) begin : g_bad
      $error("PHASE_CYCLES out of range");
    end
  endgenerate

  logic [15:0] div;

  //--------------------------------------------------------------------
  // Divider and phase ring
  //--------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !i_run) begin
      div     <= 16'h0000;
      o_phase <= PHASE_COUNT'(1);
    end else if (div == 16'(PHASE_CYCLES - 1)) begin
      div     <= 16'h0000;
      o_phase <= {o_phase[PHASE_COUNT-2:0], o_phase[PHASE_COUNT-1]};
    end else begin
      div <= div + 16'h0001;
    end
  end

endmodule : tiors_phase_clock

// ===== design/tiors_pulse_timer.sv
//----------------------------------------------------------------------
// Purpose: Retriggerable fixed-length pulse
// Assumes: LENGTH of at least one cycle
// Notes:   o_done pulses for one cycle as the pulse ends
//----------------------------------------------------------------------
`timescale 1ns/1ps
module tiors_pulse_timer #(
  parameter int LENGTH = 38
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rstn,
  // Trigger and pulse
  input  wire logic i_fire,
  output logic      o_active,
  output logic      o_done
);

  generate
    if (LENGTH < 1 || LENGTH > 65535) begin : g_bad
      $error("LENGTH out of range");
    end
  endgenerate

  logic [15:0] left;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      left     <= 16'h0000;
      o_active <= 1'b0;
      o_done   <= 1'b0;
    end else if (i_fire) begin
      left     <= 16'(LENGTH - 1);
      o_active <= 1'b1;
      o_done   <= 1'b0;
    end else if (o_active && left == 16'h0000) begin
      o_active <= 1'b0;
      o_done   <= 1'b1;
    end else begin
      left   <= o_active ? left - 16'h0001 : left;
      o_done <= 1'b0;
    end
  end

endmodule : tiors_pulse_timer

// ===== bench/tiors_cu_model.sv
// Purpose: Control unit model on the far side of the channel
// Assumes: Mode 0 busy, 1 correct device, 2 wrong device
// Notes:   Released inbound bus shows the inverse of its last value
`timescale 1ns/1ps
module tiors_cu_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  // Scenario
  input  wire logic [1:0] i_mode,
  input  wire logic [7:0] i_unit,
  input  wire logic [7:0] i_status,
  // Outbound tags
  input  wire logic       i_address_out,
  input  wire logic       i_select_out,
  input  wire logic       i_command_out,
  input  wire logic       i_oper_out,
  // Inbound tags and bus
  output logic            o_status_in,
  output logic            o_oper_in,
  output logic            o_addr_in,
  output logic [7:0]      o_bus_in
);
  int st;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st <= 0;
      {o_status_in, o_oper_in, o_addr_in} <= 3'h0;
      o_bus_in <= 8'hFF;
    end else if (!i_oper_out) begin
      st <= 0;
      {o_status_in, o_oper_in, o_addr_in} <= 3'h0;
      if (o_oper_in) o_bus_in <= ~o_bus_in;
    end else case (st)
      0: if (i_address_out && i_select_out) begin
        st <= 1;
        if (i_mode == 2'h0) o_status_in <= 1'b1;
        else begin
          {o_oper_in, o_addr_in} <= 2'h3;
          o_bus_in <= (i_mode == 2'h1) ? i_unit : ~i_unit;
        end
      end
      1: if (i_mode == 2'h0) begin
        if (i_address_out && !i_select_out) begin
          o_status_in <= 1'b0;
          st <= 0;
        end
      end else if (i_command_out) begin
        o_addr_in <= 1'b0;
        o_bus_in <= i_status;
        st <= 2;
      end
      2: begin
        o_status_in <= 1'b1;
        st <= 3;
      end
      default: if (!i_select_out) begin
        {o_status_in, o_oper_in} <= 2'h0;
        o_bus_in <= ~o_bus_in;
        st <= 0;
      end
    endcase
  end
endmodule : tiors_cu_model

// ===== bench/tiors_checker.sv
// Purpose: Port assertions for the response sequencer
// Assumes: Inputs pass a three-flop synchroniser
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ps
module tiors_checker
  import tiors_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic       i_status_in,
  input wire logic       i_addr_in,
  input wire logic       o_address_out,
  input wire logic       o_select_out,
  input wire logic       o_command_out,
  input wire logic       o_service_out,
  input wire logic       o_oper_out,
  input wire logic [7:0] o_bus_out,
  input wire logic       o_bus_out_parity,
  input wire logic [1:0] o_condition_code,
  input wire logic       o_accept,
  input wire logic       o_release,
  input wire logic       o_machine_check,
  input wire logic       o_iface_reset,
  input wire logic       o_csw_store,
  input wire logic       o_logout
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  int unsigned ifr_cnt;

  always_ff @(posedge i_clock) begin
    if (!i_rstn || !o_iface_reset) ifr_cnt <= 0;
    else ifr_cnt <= ifr_cnt + 1;
  end

  sequence s_cu_gone;
    $fell(i_status_in) && o_address_out && !o_select_out;
  endsequence
  sequence s_stored;
    !o_address_out && o_csw_store;
  endsequence

  AST_BUSY_NO_SERVICE: assert property (
    i_status_in && o_address_out |-> !o_service_out)
    else $error("service out in busy case");
  AST_BUSY_STORE: assert property (
    s_cu_gone |-> ##[1:10] s_stored)
    else $error("busy disconnect did not store");
  AST_FAULT_PATH: assert property (
    $rose(o_iface_reset) |-> o_machine_check && !o_logout)
    else $error("interface reset without machine check");
  AST_IFR_LENGTH: assert property (
    $fell(o_iface_reset) |-> ifr_cnt == IFRESET_CYCLES)
    else $error("interface reset length wrong");
  AST_OPER_OUT_LOW: assert property (
    o_iface_reset |-> !o_oper_out)
    else $error("operational out during interface reset");
  AST_IFR_STORE: assert property (
    $rose(o_iface_reset) |-> ##[0:4] o_csw_store)
    else $error("interface reset did not start store");
  AST_PROCEED_BYTE: assert property (
    o_command_out |-> o_bus_out == PROCEED_CMD && o_bus_out_parity)
    else $error("proceed byte or parity wrong");
  AST_CMD_DROP: assert property (
    $fell(i_addr_in) |-> ##[1:10] !o_command_out)
    else $error("command out held after address in");
  AST_SVC_DROP: assert property (
    $fell(i_status_in) |-> ##[1:10] !o_service_out)
    else $error("service out held after status in");
  AST_AVAIL: assert property (
    $rose(o_release) |-> (o_accept && o_condition_code == 2'h0)
    ##1 !o_release)
    else $error("available path code or release wrong");
endmodule : tiors_checker

bind tiors_sequencer tiors_checker i_chk (.i_clock, .i_rstn,
  .i_status_in, .i_addr_in, .o_address_out, .o_select_out,
  .o_command_out, .o_service_out, .o_oper_out, .o_bus_out,
  .o_bus_out_parity, .o_condition_code, .o_accept, .o_release,
  .o_machine_check, .o_iface_reset, .o_csw_store, .o_logout);

// ===== bench/tb_test_io_device_response_sequencer.sv
// Purpose: Self-checking bench for the response sequencer
// Assumes: Five scenarios, busy through logout
// Notes:   Short reset between scenarios
`timescale 1ns/1ps
module tb_test_io_device_response_sequencer
  import tiors_pkg::*;
;
  logic        i_clock, i_rstn, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr, i_bus_in, o_bus_out, unit, stat;
  logic [31:0] i_pwdata, o_prdata, q;
  logic        o_pready, o_pslverr, perr, i_status_in, i_oper_in;
  logic        i_addr_in, o_address_out, o_select_out, o_command_out;
  logic        o_service_out, o_oper_out, o_bus_out_parity, i_test_io;
  logic        i_select_channel, o_accept, o_release, o_machine_check;
  logic        o_iface_reset, o_csw_store, i_store_done, o_logout;
  logic        i_logout_done;
  logic [1:0]  o_condition_code, mode;
  logic [7:0]  exp_q[$];
  int          err_count, n_compared, cycles;

  tiors_sequencer #(.PHASE_CYCLES(2)) i_dut (.i_clock, .i_rstn, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_status_in, .i_oper_in, .i_addr_in, .i_bus_in,
    .o_address_out, .o_select_out, .o_command_out, .o_service_out,
    .o_oper_out, .o_bus_out, .o_bus_out_parity, .i_test_io,
    .i_select_channel, .o_condition_code, .o_accept, .o_release,
    .o_machine_check, .o_iface_reset, .o_csw_store, .i_store_done,
    .o_logout, .i_logout_done);

  tiors_cu_model i_cu (.i_clock, .i_rstn, .i_mode(mode), .i_unit(unit),
    .i_status(stat), .i_address_out(o_address_out),
    .i_select_out(o_select_out), .i_command_out(o_command_out),
    .i_oper_out(o_oper_out), .o_status_in(i_status_in),
    .o_oper_in(i_oper_in), .o_addr_in(i_addr_in), .o_bus_in(i_bus_in));

  initial begin
    i_clock = 0;
    forever #4 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    q = o_prdata;
    perr = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask : apb

  task automatic run(input int m);
    logic [7:0] u, s;
    int n;
    u = 8'($urandom);
    s = (m == 2) ? 8'($urandom | 1) : 8'h00;
    if (m == 1 || m == 2) exp_q.push_back(s);
    {unit, stat} <= {u, s};
    mode <= (m == 0) ? 2'h0 : (m < 3) ? 2'h1 : 2'h2;
    apb(1'b1, OFS_UNIT, {24'h0, u});
    apb(1'b0, OFS_UNIT, 32'h0);
    chk(q[7:0], u);
    {i_test_io, i_select_channel} <= 2'h3;
    apb(1'b1, OFS_CONTROL, (m == 4) ? 32'h3 : 32'h1);
    while (!(o_release || o_csw_store || o_logout)) @(negedge i_clock);
    chk(o_logout, m == 4);
    if (m == 4) begin
      @(posedge i_clock) i_logout_done <= 1'b1;
      @(posedge i_clock) i_logout_done <= 1'b0;
      while (!o_csw_store) @(negedge i_clock);
    end
    chk(o_csw_store, m != 1);
    chk(o_machine_check, m == 3);
    chk(o_address_out, 0);
    if (m == 1) chk({o_accept, o_condition_code}, 3'h4);
    if (m == 3) begin
      while (!o_iface_reset) @(negedge i_clock);
      chk(o_oper_out, 0);
      apb(1'b1, OFS_CONTROL, 32'h20);
      @(negedge i_clock);
      chk(o_machine_check, 1);
      while (o_iface_reset) @(negedge i_clock);
      chk(o_oper_out, 1);
    end
    apb(1'b0, OFS_RESULT, 32'h0);
    if (m == 1 || m == 2) chk(q[7:0], exp_q.pop_front());
    @(posedge i_clock);
    {i_test_io, i_select_channel, i_store_done} <= {2'h0, o_csw_store};
    @(posedge i_clock);
    i_store_done <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, OFS_STATE, 32'h0);
      n++;
    end while (q[15:0] !== 16'h0001 && n < 40);
    chk(q[15:0], 16'h0001);
    i_rstn <= 1'b0;
    @(posedge i_clock);
    i_rstn <= 1'b1;
  endtask : run

  initial begin
    {i_psel, i_penable, i_pwrite, i_test_io, i_select_channel} = '0;
    {i_store_done, i_logout_done, i_rstn, i_paddr, i_pwdata} = '0;
    {unit, stat, mode, err_count, n_compared, cycles} = '0;
    void'($urandom(42));
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    apb(1'b0, OFS_STATE, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk(perr, 1'b1);
    for (int m = 0; m < 5; m++) run(m);
    give_verdict();
  end
endmodule : tb_test_io_device_response_sequencer
